// ---- hw/tws_pkg.sv ----
// Shared constants and types for the two-wire slave port.
// Assumes the user side and the link side both import nothing; every use is scoped.
package tws_pkg;

  // ----------------------------------------
  // Mode select codes
  // ----------------------------------------
  localparam logic [3:0] MODE_SLV7 = 4'h6;
  localparam logic [3:0] MODE_SLV10 = 4'h7;
  localparam logic [3:0] MODE_MASTER_FW = 4'hb;
  localparam logic [3:0] MODE_SLV7_SS = 4'he;
  localparam logic [3:0] MODE_SLV10_SS = 4'hf;

  // ----------------------------------------
  // Framing constants
  // ----------------------------------------
  localparam int BYTE_W = 8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;

  // ----------------------------------------
  // State types
  // ----------------------------------------
  typedef enum logic [2:0] {LS_IDLE, LS_RECV, LS_ACK, LS_HOLD, LS_IGNORE} tws_link_state_t;
  typedef enum logic [1:0] {TS_HIGH, TS_LOW, TS_DONE} tws_ten_stage_t;

endpackage

// ---- hw/tws_sync.sv ----
// Two-flop level synchroniser, W bits wide.
// Assumes each bit is an independent level or is held stable across the crossing.
`timescale 1ns/1ps
module tws_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q_ff
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

endmodule // tws_sync

// ---- hw/tws_pulse_xing.sv ----
// Toggle based single-pulse crossing between two unrelated clocks.
// Assumes source pulses are spaced by more than three destination cycles.
`timescale 1ns/1ps
module tws_pulse_xing (
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic src_pulse,
  input wire logic dst_clk,
  input wire logic dst_rst,
  output logic dst_pulse_ff
);

  logic tgl_ff;
  logic tgl_s;
  logic tgl_d_ff;

  always_ff @(posedge src_clk or posedge src_rst) begin
    if (src_rst) begin
      tgl_ff <= 1'b0;
    end else if (src_pulse) begin
      tgl_ff <= ~tgl_ff;
    end
  end

  tws_sync #(.W(1)) u_sync (
    .clk(dst_clk),
    .rst(dst_rst),
    .d(tgl_ff),
    .q_ff(tgl_s)
  );

  always_ff @(posedge dst_clk or posedge dst_rst) begin
    if (dst_rst) begin
      tgl_d_ff <= 1'b0;
      dst_pulse_ff <= 1'b0;
    end else begin
      tgl_d_ff <= tgl_s;
      dst_pulse_ff <= tgl_s ^ tgl_d_ff;
    end
  end

endmodule // tws_pulse_xing

// ---- hw/tws_slave_port.sv ----
// Two-wire bus slave port: link engine on lclk, flags and buffer on mclk.
// Assumes an external master on SCL/SDA with pull-ups and software on the mclk side.
//
// What this block does
// - SCL is wired-AND; the longest low wins, so stretching holds the line.
// - Four-bit mode field selects 7/10-bit slave, with/without start-stop events, or master.
// - Port works only while the enable bit is set.
// - When enabled in a two-wire mode with both pins inputs, pins are open-drain.
// - Status is read-only: start, stop, data/address, update-address, direction.
// - Double buffered receive: each acknowledged byte goes to buffer and raises interrupt.
// - Byte completed while buffer still full sets overflow; the shifted byte is lost.
// - On match or following data the port acknowledges, then loads the buffer.
// - Full or overflow already set: no acknowledge, no load, interrupt still raised.
// - Buffer read clears full flag; overflow clears only by software write.
// - After enable, wait for start, then shift eight bits on rising SCL.
// - Compare shift bits 7:1 with own address on the eighth falling SCL.
// - Match with flags clear: load, set full, acknowledge, interrupt on ninth fall.
// - 10-bit first byte is known by its five top bits and must be a write.
// - Each 10-bit write address byte sets interrupt, full, update flag and holds SCL low.
// - After both bytes, repeated start plus high byte again addresses for transmit.
// - In slave mode both pins are inputs; the port overrides them with its drive.
// - Mode 1011 is firmware master with the slave logic idle.
// - Start and stop bits clear on reset or disable, then track the latest condition.
`timescale 1ns/1ps
module tws_slave_port (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] mode_select_field,
  input wire logic port_enable_bit,
  input wire logic dir_scl_input,
  input wire logic dir_sda_input,
  input wire logic [7:0] addr_wdata,
  input wire logic addr_wr,
  input wire logic buf_rd,
  input wire logic ovf_clr,
  output logic [7:0] receive_transmit_buffer,
  output logic buffer_full_flag,
  output logic receive_overflow_bit,
  output logic port_interrupt_set,
  output logic start_seen,
  output logic stop_seen,
  output logic data_not_address,
  output logic read_not_write,
  output logic update_address_flag,
  input wire logic lclk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe
);

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  function automatic logic is_slave_mode(input logic [3:0] m);
    is_slave_mode = (m == tws_pkg::MODE_SLV7) || (m == tws_pkg::MODE_SLV10) ||
                    (m == tws_pkg::MODE_SLV7_SS) || (m == tws_pkg::MODE_SLV10_SS);
  endfunction

  function automatic logic is_ten_mode(input logic [3:0] m);
    is_ten_mode = (m == tws_pkg::MODE_SLV10) || (m == tws_pkg::MODE_SLV10_SS);
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [1:0] lrst_ff;
  logic lrst;
  logic [7:0] own_addr_ff;
  logic [7:0] buf_ff;
  logic bf_ff, ov_ff, irq_ff, s_ff, p_ff, dna_ff, rw_ff, ua_ff;
  logic [7:0] cfg_s;
  logic [1:0] pin_s;
  logic en_l, blk_l, slave_l, ten_l;
  logic [3:0] mode_l;
  logic scl_d_ff, sda_d_ff;
  logic start_l, stop_l, rise_l, fall_l;
  logic addr_upd_l, ev_m, start_m, stop_m;
  tws_pkg::tws_link_state_t state_ff;
  tws_pkg::tws_ten_stage_t stage_ff;
  logic [3:0] bitcnt_ff;
  logic [7:0] shreg_ff;
  logic [7:0] laddr_ff;
  logic is_addr_ff;
  logic [7:0] ev_data_ff;
  logic ev_addr_ff, ev_rw_ff, ev_ua_ff, ev_ack_ff, ev_pulse_ff;
  logic scl_oe_ff, sda_oe_ff, scl_o_ff, sda_o_ff;
  logic nxt_match, nxt_ua;
  logic load_m, ss_mode_m;

  // ----------------------------------------
  // Link reset and crossings
  // ----------------------------------------
  // Release is synchronised so the engine never starts on a half edge
  always_ff @(posedge lclk or posedge rst) begin
    if (rst) begin
      lrst_ff <= 2'b11;
    end else begin
      lrst_ff <= {lrst_ff[0], 1'b0};
    end
  end
  assign lrst = lrst_ff[1];

  tws_sync #(.W(8)) u_cfg_sync (
    .clk(lclk),
    .rst(lrst),
    .d({port_enable_bit, mode_select_field, dir_scl_input, dir_sda_input, bf_ff | ov_ff}),
    .q_ff(cfg_s)
  );
  assign {en_l, mode_l} = cfg_s[7:3];
  assign blk_l = cfg_s[0];
  assign slave_l = en_l && is_slave_mode(mode_l) && cfg_s[2] && cfg_s[1];
  assign ten_l = is_ten_mode(mode_l);

  tws_sync #(.W(2)) u_pin_sync (
    .clk(lclk),
    .rst(lrst),
    .d({scl_i, sda_i}),
    .q_ff(pin_s)
  );

  tws_pulse_xing u_addr_x (
    .src_clk(mclk), .src_rst(rst), .src_pulse(addr_wr),
    .dst_clk(lclk), .dst_rst(lrst), .dst_pulse_ff(addr_upd_l)
  );
  tws_pulse_xing u_byte_x (
    .src_clk(lclk), .src_rst(lrst), .src_pulse(ev_pulse_ff),
    .dst_clk(mclk), .dst_rst(rst), .dst_pulse_ff(ev_m)
  );
  tws_pulse_xing u_start_x (
    .src_clk(lclk), .src_rst(lrst), .src_pulse(start_l && en_l),
    .dst_clk(mclk), .dst_rst(rst), .dst_pulse_ff(start_m)
  );
  tws_pulse_xing u_stop_x (
    .src_clk(lclk), .src_rst(lrst), .src_pulse(stop_l && en_l),
    .dst_clk(mclk), .dst_rst(rst), .dst_pulse_ff(stop_m)
  );

  // ----------------------------------------
  // Bus condition detection
  // ----------------------------------------
  always_ff @(posedge lclk or posedge lrst) begin
    if (lrst) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= pin_s[1];
      sda_d_ff <= pin_s[0];
    end
  end
  // Line levels are the wired-AND result, so a stretch by anyone is seen here
  assign start_l = pin_s[1] && scl_d_ff && sda_d_ff && !pin_s[0];
  assign stop_l = pin_s[1] && scl_d_ff && !sda_d_ff && pin_s[0];
  assign rise_l = pin_s[1] && !scl_d_ff;
  assign fall_l = !pin_s[1] && scl_d_ff;

  // ----------------------------------------
  // Address compare
  // ----------------------------------------
  always_comb begin
    nxt_match = 1'b1;
    nxt_ua = 1'b0;
    if (is_addr_ff) begin
      if (!ten_l) begin
        nxt_match = shreg_ff[7:1] == laddr_ff[7:1];
      end else begin
        unique case (stage_ff)
          tws_pkg::TS_HIGH: begin
            nxt_match = (shreg_ff[7:3] == tws_pkg::TEN_BIT_PREFIX) &&
                        (shreg_ff[7:1] == laddr_ff[7:1]) && !shreg_ff[0];
            nxt_ua = 1'b1;
          end
          tws_pkg::TS_LOW: begin
            nxt_match = shreg_ff == laddr_ff;
            nxt_ua = 1'b1;
          end
          tws_pkg::TS_DONE: begin
            nxt_match = (shreg_ff[7:3] == tws_pkg::TEN_BIT_PREFIX) &&
                        (shreg_ff[7:1] == laddr_ff[7:1]);
            nxt_ua = !shreg_ff[0];
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Link engine
  // ----------------------------------------
  always_ff @(posedge lclk or posedge lrst) begin
    if (lrst) begin
      laddr_ff <= 8'h00;
    end else if (addr_upd_l) begin
      laddr_ff <= own_addr_ff;
    end
  end

  always_ff @(posedge lclk or posedge lrst) begin
    if (lrst) begin
      state_ff <= tws_pkg::LS_IDLE;
      stage_ff <= tws_pkg::TS_HIGH;
      bitcnt_ff <= 4'h0;
      shreg_ff <= 8'h00;
      is_addr_ff <= 1'b1;
      sda_oe_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      ev_pulse_ff <= 1'b0;
      ev_data_ff <= 8'h00;
      ev_addr_ff <= 1'b0;
      ev_rw_ff <= 1'b0;
      ev_ua_ff <= 1'b0;
      ev_ack_ff <= 1'b0;
    end else begin
      ev_pulse_ff <= 1'b0;
      if (!slave_l) begin
        state_ff <= tws_pkg::LS_IDLE;
        stage_ff <= tws_pkg::TS_HIGH;
        sda_oe_ff <= 1'b0;
        scl_oe_ff <= 1'b0;
      end else if (start_l) begin
        state_ff <= tws_pkg::LS_RECV;
        bitcnt_ff <= 4'h0;
        is_addr_ff <= 1'b1;
        sda_oe_ff <= 1'b0;
        scl_oe_ff <= 1'b0;
      end else if (stop_l) begin
        state_ff <= tws_pkg::LS_IDLE;
        stage_ff <= tws_pkg::TS_HIGH;
        sda_oe_ff <= 1'b0;
        scl_oe_ff <= 1'b0;
      end else begin
        unique case (state_ff)
          tws_pkg::LS_IDLE, tws_pkg::LS_IGNORE: begin
            sda_oe_ff <= 1'b0;
          end
          tws_pkg::LS_RECV: begin
            if (rise_l && bitcnt_ff != tws_pkg::BITS_PER_BYTE) begin
              shreg_ff <= {shreg_ff[6:0], pin_s[0]};
              bitcnt_ff <= bitcnt_ff + 4'h1;
            end else if (fall_l && bitcnt_ff == tws_pkg::BITS_PER_BYTE) begin
              if (nxt_match) begin
                state_ff <= tws_pkg::LS_ACK;
                sda_oe_ff <= !blk_l;
                ev_data_ff <= shreg_ff;
                ev_addr_ff <= is_addr_ff;
                ev_rw_ff <= is_addr_ff && shreg_ff[0] && !nxt_ua;
                ev_ua_ff <= nxt_ua;
                ev_ack_ff <= !blk_l;
              end else begin
                state_ff <= tws_pkg::LS_IGNORE;
              end
            end
          end
          tws_pkg::LS_ACK: begin
            if (fall_l) begin
              sda_oe_ff <= 1'b0;
              ev_pulse_ff <= 1'b1;
              bitcnt_ff <= 4'h0;
              if (ev_addr_ff && ten_l) begin
                stage_ff <= (stage_ff == tws_pkg::TS_LOW) ? tws_pkg::TS_DONE :
                            (ev_ua_ff ? tws_pkg::TS_LOW : tws_pkg::TS_DONE);
              end
              if (ev_ua_ff) begin
                state_ff <= tws_pkg::LS_HOLD;
                scl_oe_ff <= 1'b1;
              end else if (ev_rw_ff) begin
                // Transmit handshake lives outside this block; slave backs off the bus
                state_ff <= tws_pkg::LS_IGNORE;
              end else begin
                state_ff <= tws_pkg::LS_RECV;
                is_addr_ff <= 1'b0;
              end
            end
          end
          tws_pkg::LS_HOLD: begin
            if (addr_upd_l) begin
              scl_oe_ff <= 1'b0;
              state_ff <= tws_pkg::LS_RECV;
              is_addr_ff <= stage_ff == tws_pkg::TS_LOW;
            end
          end
          default: begin
            state_ff <= tws_pkg::LS_IDLE;
          end
        endcase
      end
    end
  end

  // Open-drain: the pin value is always low, only the enable moves
  always_ff @(posedge lclk or posedge lrst) begin
    if (lrst) begin
      scl_o_ff <= 1'b0;
      sda_o_ff <= 1'b0;
    end else begin
      scl_o_ff <= 1'b0;
      sda_o_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Software side: address, buffer, flags
  // ----------------------------------------
  assign load_m = ev_m && ev_ack_ff && !bf_ff && !ov_ff;
  assign ss_mode_m = (mode_select_field == tws_pkg::MODE_SLV7_SS) ||
                     (mode_select_field == tws_pkg::MODE_SLV10_SS) ||
                     (mode_select_field == tws_pkg::MODE_MASTER_FW);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      own_addr_ff <= 8'h00;
    end else if (addr_wr) begin
      own_addr_ff <= addr_wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      buf_ff <= 8'h00;
    end else if (load_m) begin
      buf_ff <= ev_data_ff;
    end
  end

  // Event sets win over same-cycle software clears
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bf_ff <= 1'b0;
      ov_ff <= 1'b0;
      ua_ff <= 1'b0;
      dna_ff <= 1'b0;
      rw_ff <= 1'b0;
    end else if (!port_enable_bit) begin
      bf_ff <= 1'b0;
      ov_ff <= 1'b0;
      ua_ff <= 1'b0;
      dna_ff <= 1'b0;
      rw_ff <= 1'b0;
    end else begin
      if (load_m) begin
        bf_ff <= 1'b1;
      end else if (buf_rd) begin
        bf_ff <= 1'b0;
      end
      if (ev_m && bf_ff) begin
        ov_ff <= 1'b1;
      end else if (ovf_clr) begin
        ov_ff <= 1'b0;
      end
      if (ev_m && ev_ua_ff) begin
        ua_ff <= 1'b1;
      end else if (addr_wr) begin
        ua_ff <= 1'b0;
      end
      if (ev_m) begin
        dna_ff <= !ev_addr_ff;
      end
      if (ev_m && ev_addr_ff) begin
        rw_ff <= ev_rw_ff;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_ff <= 1'b0;
      p_ff <= 1'b0;
    end else if (!port_enable_bit) begin
      s_ff <= 1'b0;
      p_ff <= 1'b0;
    end else if (start_m) begin
      s_ff <= 1'b1;
      p_ff <= 1'b0;
    end else if (stop_m) begin
      s_ff <= 1'b0;
      p_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= port_enable_bit && (ev_m || (ss_mode_m && (start_m || stop_m)));
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign receive_transmit_buffer = buf_ff;
  assign buffer_full_flag = bf_ff;
  assign receive_overflow_bit = ov_ff;
  assign port_interrupt_set = irq_ff;
  assign start_seen = s_ff;
  assign stop_seen = p_ff;
  assign data_not_address = dna_ff;
  assign read_not_write = rw_ff;
  assign update_address_flag = ua_ff;
  assign scl_o = scl_o_ff;
  assign scl_oe = scl_oe_ff;
  assign sda_o = sda_o_ff;
  assign sda_oe = sda_oe_ff;

endmodule // tws_slave_port

// ---- sim/tws_slave_port_sva.sv ----
// Concurrent checks on the ports of the two-wire slave port.
// Assumes mclk and lclk domains share the active-high rst.
`timescale 1ns/1ps
module tws_slave_port_sva (
  input wire logic mclk,
  input wire logic lclk,
  input wire logic rst,
  input wire logic [3:0] mode_select_field,
  input wire logic port_enable_bit,
  input wire logic dir_scl_input,
  input wire logic dir_sda_input,
  input wire logic addr_wr,
  input wire logic buf_rd,
  input wire logic ovf_clr,
  input wire logic [7:0] receive_transmit_buffer,
  input wire logic buffer_full_flag,
  input wire logic receive_overflow_bit,
  input wire logic port_interrupt_set,
  input wire logic start_seen,
  input wire logic stop_seen,
  input wire logic update_address_flag,
  input wire logic scl_i,
  input wire logic scl_oe,
  input wire logic sda_oe
);
  // ----------------------------------------
  // System clock side
  // ----------------------------------------
  // Modes 0110/0111 raise no start/stop events, so every pulse is a byte
  chk_ovf_on_full: assert property (@(posedge mclk) disable iff (rst)
    port_interrupt_set && $past(buffer_full_flag) && !mode_select_field[3] |-> receive_overflow_bit)
    else $error("overflow not set on byte into full buffer");
  chk_buf_frozen: assert property (@(posedge mclk) disable iff (rst)
    $past(buffer_full_flag || receive_overflow_bit) |-> $stable(receive_transmit_buffer))
    else $error("buffer changed while full or overflowed");
  chk_bf_read: assert property (@(posedge mclk) disable iff (rst)
    buf_rd && port_enable_bit |=> !buffer_full_flag || port_interrupt_set)
    else $error("buffer read did not clear full flag");
  chk_ovf_sticky: assert property (@(posedge mclk) disable iff (rst)
    receive_overflow_bit && !ovf_clr && port_enable_bit |=> receive_overflow_bit)
    else $error("overflow cleared without software clear");
  chk_ovf_clear: assert property (@(posedge mclk) disable iff (rst)
    ovf_clr && port_enable_bit |=> !receive_overflow_bit || port_interrupt_set)
    else $error("overflow clear ignored");
  chk_disable_clears: assert property (@(posedge mclk) disable iff (rst)
    !port_enable_bit [*2] |-> !buffer_full_flag && !receive_overflow_bit && !update_address_flag
      && !start_seen && !stop_seen)
    else $error("status kept while disabled");
  chk_start_stop_excl: assert property (@(posedge mclk) disable iff (rst)
    !(start_seen && stop_seen))
    else $error("start and stop both flagged");
  chk_ua_sticky: assert property (@(posedge mclk) disable iff (rst)
    update_address_flag && !addr_wr && port_enable_bit |=> update_address_flag)
    else $error("update flag dropped without address write");
  // ----------------------------------------
  // Link clock side checks; covers on both clocks
  // ----------------------------------------
  chk_idle_no_drive: assert property (@(posedge lclk) disable iff (rst)
    (!port_enable_bit || mode_select_field == tws_pkg::MODE_MASTER_FW || !dir_scl_input || !dir_sda_input) [*6]
      |-> !sda_oe && !scl_oe)
    else $error("pins driven while slave idle");
  // Acknowledge must not drop while the master holds SCL high
  chk_ack_steady: assert property (@(posedge lclk) disable iff (rst)
    sda_oe && scl_i |=> sda_oe)
    else $error("acknowledge released during SCL high");
  cov_overflow: cover property (@(posedge mclk) disable iff (rst) $rose(receive_overflow_bit));
  cov_ack: cover property (@(posedge lclk) disable iff (rst) $rose(sda_oe));
  cov_hold: cover property (@(posedge lclk) disable iff (rst) $rose(scl_oe));
endmodule // tws_slave_port_sva

bind tws_slave_port tws_slave_port_sva u_sva (.mclk(mclk), .lclk(lclk), .rst(rst),
  .mode_select_field(mode_select_field), .port_enable_bit(port_enable_bit), .dir_scl_input(dir_scl_input),
  .dir_sda_input(dir_sda_input), .addr_wr(addr_wr), .buf_rd(buf_rd), .ovf_clr(ovf_clr),
  .receive_transmit_buffer(receive_transmit_buffer), .buffer_full_flag(buffer_full_flag),
  .receive_overflow_bit(receive_overflow_bit), .port_interrupt_set(port_interrupt_set),
  .start_seen(start_seen), .stop_seen(stop_seen), .update_address_flag(update_address_flag),
  .scl_i(scl_i), .scl_oe(scl_oe), .sda_oe(sda_oe));

// ---- sim/tws_master_model.sv ----
// Behavioural single bus master with pull-ups on both lines.
// Assumes the slave drives through output enables; timing is by delay.
`timescale 1ns/1ps
module tws_master_model #(
  parameter int HALF_NS = 257
) (
  input wire logic scl_oe,
  input wire logic scl_o,
  input wire logic sda_oe,
  input wire logic sda_o,
  output logic scl_w,
  output logic sda_w
);
  logic m_scl_low = 1'b0;
  logic m_sda_low = 1'b0;
  // Released lines float to the pull-up level
  assign scl_w = ~(m_scl_low | (scl_oe & ~scl_o));
  assign sda_w = ~(m_sda_low | (sda_oe & ~sda_o));
  // Wait out a slave that stretches the low phase
  task automatic rel_scl();
    int n;
    m_scl_low = 1'b0;
    n = 0;
    while (scl_w !== 1'b1 && n < 4000) begin
      #10;
      n++;
    end
  endtask
  task automatic start_cond();
    m_sda_low = 1'b0;
    #HALF_NS;
    rel_scl();
    #HALF_NS;
    m_sda_low = 1'b1;
    #HALF_NS;
    m_scl_low = 1'b1;
    #(HALF_NS / 4);
  endtask
  task automatic stop_cond();
    m_sda_low = 1'b1;
    #HALF_NS;
    rel_scl();
    #HALF_NS;
    m_sda_low = 1'b0;
    #HALF_NS;
  endtask
  // Eight bits MSB first, released ninth bit; a lost bit drops data drive, clocking goes on
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic lost = 1'b0;
    for (int i = 7; i >= -1; i--) begin
      m_sda_low = (i >= 0 && !lost) ? ~b[i] : 1'b0;
      #HALF_NS;
      rel_scl();
      if (i >= 0 && b[i] && !sda_w) lost = 1'b1;
      #HALF_NS;
      if (i < 0) ack = ~sda_w;
      m_scl_low = 1'b1;
      // Data moves only well after SCL has fallen
      #(HALF_NS / 4);
    end
    #HALF_NS;
  endtask
endmodule // tws_master_model

// ---- sim/tws_slave_port_tb_top.sv ----
// Self-checking bench for the two-wire slave port.
// Assumes the master model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tws_slave_port_tb_top;
  logic mclk;
  logic lclk;
  logic rst;
  logic [3:0] mode_select_field;
  logic port_enable_bit;
  logic dir_scl_input;
  logic dir_sda_input;
  logic [7:0] addr_wdata;
  logic addr_wr;
  logic buf_rd;
  logic ovf_clr;
  logic [7:0] receive_transmit_buffer;
  logic buffer_full_flag;
  logic receive_overflow_bit;
  logic port_interrupt_set;
  logic start_seen;
  logic stop_seen;
  logic data_not_address;
  logic read_not_write;
  logic update_address_flag;
  logic scl_w;
  logic sda_w;
  logic scl_o;
  logic scl_oe;
  logic sda_o;
  logic sda_oe;
  logic [7:0] irq_cnt;
  logic [7:0] mark;
  int error_cnt;
  int check_count;

  tws_slave_port dut (.mclk(mclk), .rst(rst), .mode_select_field(mode_select_field),
    .port_enable_bit(port_enable_bit), .dir_scl_input(dir_scl_input), .dir_sda_input(dir_sda_input),
    .addr_wdata(addr_wdata), .addr_wr(addr_wr), .buf_rd(buf_rd), .ovf_clr(ovf_clr),
    .receive_transmit_buffer(receive_transmit_buffer), .buffer_full_flag(buffer_full_flag),
    .receive_overflow_bit(receive_overflow_bit), .port_interrupt_set(port_interrupt_set),
    .start_seen(start_seen), .stop_seen(stop_seen), .data_not_address(data_not_address),
    .read_not_write(read_not_write), .update_address_flag(update_address_flag), .lclk(lclk),
    .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));
  tws_master_model u_mst (.scl_oe(scl_oe), .scl_o(scl_o), .sda_oe(sda_oe), .sda_o(sda_o),
    .scl_w(scl_w), .sda_w(sda_w));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Half-ns phase keeps link edges off every bus change
  initial begin
    lclk = 1'b0;
    #5.5;
    forever #16 lclk = ~lclk;
  end
  always @(posedge mclk) begin
    if (rst) irq_cnt <= 8'h00;
    else if (port_interrupt_set === 1'b1) irq_cnt <= irq_cnt + 8'h01;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr_addr(input logic [7:0] a);
    @(posedge mclk);
    addr_wdata <= a;
    addr_wr <= 1'b1;
    @(posedge mclk);
    addr_wr <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic sw_pulse(input logic rd);
    @(posedge mclk);
    if (rd) buf_rd <= 1'b1;
    else ovf_clr <= 1'b1;
    @(posedge mclk);
    buf_rd <= 1'b0;
    ovf_clr <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic cfg(input logic [3:0] m, input logic [7:0] a, input logic sda_in);
    @(posedge mclk);
    mode_select_field <= m;
    port_enable_bit <= 1'b1;
    dir_sda_input <= sda_in;
    wr_addr(a);
    repeat (100) @(posedge mclk);
  endtask
  task automatic xfer(input logic [7:0] b, input logic e_ack, input logic [7:0] e_buf, input logic e_ovf,
                      input logic [7:0] e_irq);
    logic ack;
    logic [7:0] base;
    base = irq_cnt;
    u_mst.send_byte(b, ack);
    @(negedge mclk);
    chk("ack", ack, e_ack);
    chk("buffer", receive_transmit_buffer, e_buf);
    chk("overflow", receive_overflow_bit, e_ovf);
    chk("irq", irq_cnt - base, e_irq);
  endtask

  initial begin
    #300000;
    error_cnt++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    mode_select_field = tws_pkg::MODE_SLV7;
    port_enable_bit = 1'b0;
    dir_scl_input = 1'b1;
    dir_sda_input = 1'b1;
    addr_wdata = 8'h00;
    addr_wr = 1'b0;
    buf_rd = 1'b0;
    ovf_clr = 1'b0;
    error_cnt = 0;
    check_count = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    cfg(tws_pkg::MODE_SLV7, 8'ha4, 1'b1);
    // ----------------------------------------
    // Seven-bit write with flags clear, full only, and overflow only
    // ----------------------------------------
    u_mst.start_cond();
    xfer(8'ha4, 1'b1, 8'ha4, 1'b0, 8'h01);
    chk("address", data_not_address, 1'b0);
    chk("direction", read_not_write, 1'b0);
    chk("start", start_seen, 1'b1);
    sw_pulse(1'b1);
    chk("full", buffer_full_flag, 1'b0);
    xfer(8'h3c, 1'b1, 8'h3c, 1'b0, 8'h01);
    chk("data", data_not_address, 1'b1);
    xfer(8'h5a, 1'b0, 8'h3c, 1'b1, 8'h01);
    sw_pulse(1'b0);
    chk("overflow", receive_overflow_bit, 1'b0);
    xfer(8'h77, 1'b0, 8'h3c, 1'b1, 8'h01);
    sw_pulse(1'b1);
    xfer(8'h11, 1'b0, 8'h3c, 1'b1, 8'h01);
    sw_pulse(1'b0);
    xfer(8'h22, 1'b1, 8'h22, 1'b0, 8'h01);
    sw_pulse(1'b1);
    u_mst.stop_cond();
    @(negedge mclk);
    chk("stop", stop_seen, 1'b1);
    chk("start", start_seen, 1'b0);
    // Foreign address and the bytes after it are ignored
    u_mst.start_cond();
    xfer(8'h40, 1'b0, 8'h22, 1'b0, 8'h00);
    xfer(8'h55, 1'b0, 8'h22, 1'b0, 8'h00);
    u_mst.stop_cond();
    u_mst.start_cond();
    xfer(8'ha4, 1'b1, 8'ha4, 1'b0, 8'h01);
    @(posedge mclk);
    port_enable_bit <= 1'b0;
    repeat (3) @(negedge mclk);
    chk("full", buffer_full_flag, 1'b0);
    chk("start", start_seen, 1'b0);
    u_mst.stop_cond();
    $display("test seven_bit done");
    // ----------------------------------------
    // Ten-bit addressing with stretch and reread
    // ----------------------------------------
    cfg(tws_pkg::MODE_SLV10, 8'hf2, 1'b1);
    u_mst.start_cond();
    xfer(8'hf2, 1'b1, 8'hf2, 1'b0, 8'h01);
    chk("update", update_address_flag, 1'b1);
    repeat (20) @(negedge mclk);
    chk("scl held", scl_oe, 1'b1);
    chk("pin level", {6'h00, scl_o, sda_o}, 8'h00);
    sw_pulse(1'b1);
    wr_addr(8'h34);
    chk("update", update_address_flag, 1'b0);
    xfer(8'h34, 1'b1, 8'h34, 1'b0, 8'h01);
    chk("update", update_address_flag, 1'b1);
    sw_pulse(1'b1);
    wr_addr(8'hf2);
    xfer(8'h99, 1'b1, 8'h99, 1'b0, 8'h01);
    sw_pulse(1'b1);
    u_mst.start_cond();
    xfer(8'hf3, 1'b1, 8'hf3, 1'b0, 8'h01);
    chk("direction", read_not_write, 1'b1);
    chk("update", update_address_flag, 1'b0);
    sw_pulse(1'b1);
    u_mst.stop_cond();
    $display("test ten_bit done");
    // ----------------------------------------
    // Event modes, idle slave, pin direction
    // ----------------------------------------
    cfg(tws_pkg::MODE_SLV7_SS, 8'ha4, 1'b1);
    mark = irq_cnt;
    u_mst.start_cond();
    u_mst.stop_cond();
    @(negedge mclk);
    chk("events", irq_cnt - mark, 8'h02);
    cfg(tws_pkg::MODE_MASTER_FW, 8'ha4, 1'b1);
    u_mst.start_cond();
    xfer(8'ha4, 1'b0, 8'hf3, 1'b0, 8'h00);
    u_mst.stop_cond();
    cfg(tws_pkg::MODE_SLV7, 8'ha4, 1'b0);
    u_mst.start_cond();
    xfer(8'ha4, 1'b0, 8'hf3, 1'b0, 8'h00);
    u_mst.stop_cond();
    $display("test modes done");
    finish_test();
  end
endmodule // tws_slave_port_tb_top
